// ---- shared/codec_pkg.sv ----
// Shared constants, register map and packed carriers for the codec serial port.
package codec_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SETTLE_MS = 50;
  localparam int SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
  localparam int SCLK_TIMEOUT = 255;
  localparam int BCLK_HALF_BASE = 4;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and widths
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_TX = 8'h00;
  localparam logic [7:0] REG_RX = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam int CW_W = 24;
  localparam int SLOT_BITS = 32;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_SCLK = 2'h3;
  localparam logic [8:0] BIT_IDLE = 9'h1ff;
  // Version code carried in the status stream; the value is arbitrary.
  localparam logic [3:0] VERSION_ID = 4'h5;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    serial_mode_one,
    serial_mode_two,
    serial_mode_three,
    serial_mode_four
  } serial_mode_t;

  typedef struct packed {
    logic [8:1] multi;
    logic [2:0] mode;
    logic bclk;
    logic fsync;
    logic serial_audio_in;
    logic power_down_n;
    logic di1;
  } pin_in_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [5:0] atten_l;
    logic [5:0] atten_r;
    logic [1:0] gain_l;
    logic [1:0] gain_r;
    logic mute;
    logic insel;
    logic mask;
    logic spare;
  } ctrl_word_t;

  typedef struct packed {
    logic [11:0] zero;
    logic [3:0] version;
    logic [3:0] dout;
    logic [3:0] din;
    logic power_down_n;
    logic irq;
    logic conversion_valid_flag;
    logic [1:0] err;
    logic master;
    logic [1:0] mode;
  } status_t;

endpackage : codec_pkg

// ---- verilog/codec_serial_port.sv ----
// Digital side of a stereo audio converter: serial audio port, mode pins, control port.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps

module codec_serial_port #(
  parameter int SETTLE_CYC = codec_pkg::SETTLE_CYCLES,
  parameter int SCLK_TMO = codec_pkg::SCLK_TIMEOUT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_select_a_i,
  input wire logic mode_select_b_i,
  input wire logic mode_select_c_i,
  input wire logic [8:1] multi_pin_i,
  output logic [8:1] multi_pin_o,
  output logic [8:1] multi_pin_oe_o,
  input wire logic bit_clock_i,
  output logic bit_clock_o,
  output logic bit_clock_oe_o,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe_o,
  input wire logic serial_audio_in_i,
  output logic serial_audio_out_o,
  input wire logic par_in_bit_1_i,
  output logic par_out_bit_1_o,
  input wire logic power_down_n_i,
  input wire logic left_clip_flag_i,
  input wire logic right_clip_flag_i
);
  import codec_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Gives {in slot, position} for a frame bit index.
  function automatic logic [5:0] slot_pos(logic [8:0] b, logic m4, logic [1:0] slot,
                                          logic [8:0] len);
    logic hit;
    hit = (b < len) & (m4 ? (b[6:5] == slot) : ((b[7:6] == slot) & ~b[5]));
    slot_pos = {hit, b[4:0]};
  endfunction : slot_pos

  // Next bit index of a frame, wrapping to zero after its last bit.
  function automatic logic [8:0] wrap_next(logic [8:0] b, logic [8:0] len);
    wrap_next = (b + 9'h1 >= len) ? 9'h0 : b + 9'h1;
  endfunction : wrap_next

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  pin_in_t pin_raw;
  pin_in_t meta_ff;
  pin_in_t sync_ff;

  assign pin_raw = {multi_pin_i, mode_select_c_i, mode_select_b_i, mode_select_a_i,
                    bit_clock_i, frame_sync_i, serial_audio_in_i, power_down_n_i,
                    par_in_bit_1_i};

  // Every pin but the two clip flags passes two flops; only the second stage is read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  serial_mode_t mode;
  logic is_m12;
  logic is_m3;
  logic is_m4;
  logic master;
  logic [2:0] fs_code;
  logic [1:0] my_slot;
  logic [8:0] frame_bits;
  logic [3:0] din;
  logic [8:1] mp;

  // Third select high picks mode four; otherwise the low pair picks one to three.
  assign mp = sync_ff.multi;
  assign mode = sync_ff.mode[2] ? serial_mode_four :
                sync_ff.mode[1] ? serial_mode_three :
                sync_ff.mode[0] ? serial_mode_two : serial_mode_one;
  assign is_m12 = (mode == serial_mode_one) | (mode == serial_mode_two);
  assign is_m3 = (mode == serial_mode_three);
  assign is_m4 = (mode == serial_mode_four);
  assign master = is_m3 ? mp[4] : (is_m4 & sync_ff.mode[0]);
  assign fs_code = is_m4 ? {mp[8], mp[7], mp[6]} : {mp[3], mp[2], mp[1]};
  assign my_slot = (is_m4 & (master | ~mp[6])) ? 2'h0 : {mp[8], mp[7]};
  assign frame_bits = is_m12 ? 9'h100 :
                      is_m3 ? (master ? ((mp[2:1] == 2'h0) ? 9'h040 : 9'h080) :
                               (mp[2] ? 9'h100 : (mp[1] ? 9'h080 : 9'h040))) :
                      master ? 9'h020 :
                      mp[6] ? 9'h080 : (mp[7] ? 9'h040 : 9'h020);
  // Parallel inputs that the current mode routes into the sub-frame.
  assign din = {is_m12 & mp[4], (is_m12 | (is_m3 & ~master)) & mp[3],
                (is_m12 | is_m3) & mp[6], sync_ff.di1};

  // ---------------------------------------------------------------------------
  // Calibration and power-down
  // ---------------------------------------------------------------------------
  logic [31:0] cal_cnt_ff;
  logic cal_busy;
  logic conversion_valid_flag;

  // Reset release or power-down exit reloads the settling and calibration count.
  always_ff @(posedge clk_i) begin
    if (rst_i || !sync_ff.power_down_n) begin
      cal_cnt_ff <= 32'(SETTLE_CYC);
    end else if (cal_cnt_ff != 32'h0) begin
      cal_cnt_ff <= cal_cnt_ff - 32'h1;
    end
  end

  assign cal_busy = (cal_cnt_ff != 32'h0);
  assign conversion_valid_flag = ~cal_busy & sync_ff.power_down_n;

  // ---------------------------------------------------------------------------
  // Master clock and frame sync generation
  // ---------------------------------------------------------------------------
  logic gen_en;
  logic [7:0] half;
  logic [7:0] div_ff;
  logic bclk_ff;
  logic fsync_gen_ff;
  logic [8:0] mbit_ff;
  logic [8:0] nxt_mbit;
  logic gen_fall;

  assign gen_en = master & conversion_valid_flag;
  assign half = 8'(BCLK_HALF_BASE * (int'(fs_code) + 1));
  assign gen_fall = gen_en & bclk_ff & (div_ff == half - 8'h1);
  assign nxt_mbit = wrap_next(mbit_ff, frame_bits);

  // Divides the system clock down to the bit clock while master and calibrated.
  always_ff @(posedge clk_i) begin
    if (rst_i || !gen_en) begin
      div_ff <= 8'h0;
      bclk_ff <= 1'b0;
    end else if (div_ff == half - 8'h1) begin
      div_ff <= 8'h0;
      bclk_ff <= ~bclk_ff;
    end else begin
      div_ff <= div_ff + 8'h1;
    end
  end

  // Sync is high for the first bit of each generated frame after the first.
  always_ff @(posedge clk_i) begin
    if (rst_i || !gen_en) begin
      mbit_ff <= 9'h0;
      fsync_gen_ff <= 1'b0;
    end else if (gen_fall) begin
      mbit_ff <= nxt_mbit;
      fsync_gen_ff <= (nxt_mbit == 9'h0);
    end
  end

  // ---------------------------------------------------------------------------
  // Audio frame tracking
  // ---------------------------------------------------------------------------
  logic bclk_now;
  logic fsync_now;
  logic bprev_ff;
  logic brise;
  logic bfall;
  logic [1:0] fs_hist_ff;
  logic fs_edge;
  logic start;
  logic [8:0] tx_idx;
  logic [8:0] bit_ff;
  logic [8:0] cur_bit;
  logic [5:0] rx_sp;
  logic [5:0] tx_sp;
  logic [31:0] rx_sh_ff;
  logic [31:0] rx_word_ff;
  logic [15:0] tx_sample_ff;
  logic [31:0] tx_word;
  logic serial_audio_out_ff;

  assign bclk_now = master ? bclk_ff : sync_ff.bclk;
  assign fsync_now = master ? fsync_gen_ff : sync_ff.fsync;
  assign brise = bclk_now & ~bprev_ff;
  assign bfall = ~bclk_now & bprev_ff;
  assign fs_edge = fsync_now & ~fs_hist_ff[0];
  // Modes one/two need sync high on two bit clocks; others need a rising edge.
  assign start = is_m12 ? (fsync_now & fs_hist_ff[0] & ~fs_hist_ff[1]) : fs_edge;
  // An idle tracker takes a sync rise as bit zero, so the first bit is not lost.
  // A running tracker wraps at the frame end, so back-to-back frames keep bit zero.
  assign cur_bit = start ? (is_m12 ? 9'h1 : 9'h0) :
                   (bit_ff != BIT_IDLE) ? wrap_next(bit_ff, frame_bits) :
                   (fs_edge ? 9'h0 : BIT_IDLE);
  assign tx_idx = (bit_ff == BIT_IDLE) ? 9'h0 : wrap_next(bit_ff, frame_bits);
  assign rx_sp = slot_pos(cur_bit, is_m4, my_slot, frame_bits);
  assign tx_sp = slot_pos(tx_idx, is_m4, my_slot, frame_bits);
  assign tx_word = {tx_sample_ff, 12'h000, din};

  // Tracks the bit index of the frame on each bit clock rise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bprev_ff <= 1'b0;
      fs_hist_ff <= 2'h0;
      bit_ff <= BIT_IDLE;
    end else begin
      bprev_ff <= bclk_now;
      if (brise) begin
        fs_hist_ff <= {fs_hist_ff[0], fsync_now};
        bit_ff <= cur_bit;
      end
    end
  end

  // Serial input is taken on the rise inside this device's slot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh_ff <= 32'h0;
      rx_word_ff <= 32'h0;
    end else if (brise && rx_sp[5]) begin
      rx_sh_ff <= {rx_sh_ff[30:0], sync_ff.serial_audio_in};
      if (rx_sp[4:0] == 5'h1f) begin
        rx_word_ff <= {rx_sh_ff[30:0], sync_ff.serial_audio_in};
      end
    end
  end

  // Serial output changes on the fall, one bit ahead of the receiver.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_audio_out_ff <= 1'b0;
    end else if (bfall) begin
      serial_audio_out_ff <= tx_sp[5] & tx_word[5'h1f - tx_sp[4:0]];
    end
  end

  // ---------------------------------------------------------------------------
  // Bit clock range check
  // ---------------------------------------------------------------------------
  logic [15:0] tmo_ff;
  logic [1:0] err_ff;

  // Slave clock missing for too long reports error three.
  always_ff @(posedge clk_i) begin
    if (rst_i || master || brise || bfall) begin
      tmo_ff <= 16'h0;
      err_ff <= ERR_NONE;
    end else begin
      if (tmo_ff != 16'hffff) begin
        tmo_ff <= tmo_ff + 16'h1;
      end
      err_ff <= (tmo_ff >= 16'(SCLK_TMO)) ? ERR_SCLK : ERR_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Control port
  // ---------------------------------------------------------------------------
  logic ctrl_bit_clock;
  logic csel;
  logic [1:0] cprev_ff;
  logic ck_rise;
  logic ck_fall;
  logic sel_rise;
  logic sel_fall;
  logic [CW_W-1:0] cw_sh_ff;
  ctrl_word_t ctrl_word_ff;
  logic [CW_W-1:0] st_sh_ff;
  logic [CW_W-1:0] status_word;
  logic irq_pend_ff;

  assign ctrl_bit_clock = mp[3];
  assign csel = mp[4];
  assign ck_rise = ctrl_bit_clock & ~cprev_ff[1];
  assign ck_fall = ~ctrl_bit_clock & cprev_ff[1];
  assign sel_rise = is_m4 & csel & ~cprev_ff[0];
  assign sel_fall = is_m4 & ~csel & cprev_ff[0];
  assign status_word = {VERSION_ID, err_ff, conversion_valid_flag, left_clip_flag_i, right_clip_flag_i,
                        sync_ff.di1, irq_pend_ff, 13'h0};

  // Shifts control data in and latches it when the select rises.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cprev_ff <= 2'h3;
      cw_sh_ff <= '0;
      ctrl_word_ff <= '0;
    end else begin
      cprev_ff <= {ctrl_bit_clock, csel};
      if (is_m4 && !csel && ck_fall) begin
        cw_sh_ff <= {cw_sh_ff[CW_W-2:0], mp[2]};
      end
      if (sel_rise) begin
        ctrl_word_ff <= cw_sh_ff;
      end
    end
  end

  // Status word loads on select fall and shifts on each control clock rise while select is low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_sh_ff <= '0;
    end else if (sel_fall) begin
      st_sh_ff <= status_word;
    end else if (is_m4 && !csel && ck_rise) begin
      st_sh_ff <= {st_sh_ff[CW_W-2:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt
  // ---------------------------------------------------------------------------
  logic [4:0] evp_ff;
  logic [4:0] ev_now;
  logic ev;

  assign ev_now = {conversion_valid_flag, sync_ff.di1, left_clip_flag_i, right_clip_flag_i, err_ff == ERR_SCLK};
  assign ev = (ev_now[4] ^ evp_ff[4]) | (ev_now[3] ^ evp_ff[3]) |
              (ev_now[2] & ~evp_ff[2]) | (ev_now[1] & ~evp_ff[1]) |
              (~ev_now[0] & evp_ff[0]);

  // A new event wins over the clear made by reading the control port.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evp_ff <= 5'h0;
      irq_pend_ff <= 1'b0;
    end else begin
      evp_ff <= ev_now;
      if (is_m4 && ev) begin
        irq_pend_ff <= 1'b1;
      end else if (sel_fall) begin
        irq_pend_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  logic [8:1] nxt_mp_o;
  logic [8:1] nxt_mp_oe;

  assign nxt_mp_o = {3'h0, is_m4 ? 1'b0 : rx_word_ff[1], 2'h0,
                     is_m12 & rx_word_ff[2],
                     is_m4 ? st_sh_ff[CW_W-1] : (is_m12 & rx_word_ff[3])};
  assign nxt_mp_oe = {3'h0, (is_m4 & irq_pend_ff & ~ctrl_word_ff.mask) | is_m12 | is_m3,
                      2'h0, is_m12, is_m12 | is_m4};

  // All pin outputs come from flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      multi_pin_o <= 8'h00;
      multi_pin_oe_o <= 8'h00;
      bit_clock_oe_o <= 1'b0;
      frame_sync_oe_o <= 1'b0;
    end else begin
      multi_pin_o <= nxt_mp_o;
      multi_pin_oe_o <= nxt_mp_oe;
      bit_clock_oe_o <= master;
      frame_sync_oe_o <= master;
    end
  end

  assign bit_clock_o = bclk_ff;
  assign frame_sync_o = fsync_gen_ff;
  assign serial_audio_out_o = serial_audio_out_ff;
  assign par_out_bit_1_o = rx_word_ff[0];

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  logic take;
  logic wr_tx;
  logic [31:0] rd_mux;
  status_t status;

  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_tx = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i == REG_TX);
  assign status = {12'h000, VERSION_ID, rx_word_ff[3:0], din, ~sync_ff.power_down_n, irq_pend_ff,
                   conversion_valid_flag, err_ff, master, mode};
  assign rd_mux = (wb_adr_i == REG_TX) ? {16'h0000, tx_sample_ff} :
                  (wb_adr_i == REG_RX) ? rx_word_ff :
                  (wb_adr_i == REG_STATUS) ? status :
                  (wb_adr_i == REG_CTRL) ? {8'h00, ctrl_word_ff} : 32'h0;

  // Answers one cycle after the request; writes land on the acknowledged edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      tx_sample_ff <= 16'h0;
    end else begin
      wb_ack_o <= take;
      if (take) begin
        wb_dat_o <= rd_mux;
      end
      if (wr_tx && wb_sel_i[0]) begin
        tx_sample_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wr_tx && wb_sel_i[1]) begin
        tx_sample_ff[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ctrl_reset_a: assert property ($fell(rst_i) |-> ctrl_word_ff == '0)
    else $error("control word not zero after reset");
  ctrl_latch_a: assert property (sel_rise |=> ctrl_word_ff == $past(cw_sh_ff))
    else $error("control word not latched on select rise");
  ctrl_hold_a: assert property (!sel_rise |=> $stable(ctrl_word_ff))
    else $error("control word changed without select rise");
  ctrl_sample_a: assert property (is_m4 && !csel && ck_fall |=> cw_sh_ff[0] == $past(mp[2]))
    else $error("control input not taken on clock fall");
  irq_mask_a: assert property (ctrl_word_ff.mask |=> !multi_pin_oe_o[5])
    else $error("masked interrupt still driven");
  irq_set_a: assert property (is_m4 && ev |=> irq_pend_ff ##1 (multi_pin_oe_o[5] ||
    $past(ctrl_word_ff.mask) || !is_m4))
    else $error("event did not raise interrupt");
  par_out_a: assert property (is_m12 |=> multi_pin_o[1] == $past(rx_word_ff[3]))
    else $error("parallel output four does not follow sub-frame");
  master_drive_a: assert property (master |=> bit_clock_oe_o && frame_sync_oe_o)
    else $error("master does not drive clock and sync");
  cal_start_a: assert property ($fell(rst_i) |-> !conversion_valid_flag ##1 !conversion_valid_flag)
    else $error("conversion valid before calibration");
  rx_shift_a: assert property (brise && rx_sp[5] |=> rx_sh_ff[0] == $past(sync_ff.serial_audio_in))
    else $error("serial input not taken on bit clock rise");

endmodule : codec_serial_port

// ---- dv/audio_partner.sv ----
// Behavioural far-side serial audio master that feeds a slave-mode codec port.
`timescale 1ns/1ps

module audio_partner (
  output logic bclk_o,
  output logic fsync_o,
  output logic serial_audio_in_o,
  input wire logic serial_audio_out_i
);
  logic [31:0] got;

  // All lines rest low until the first frame is sent.
  initial begin
    bclk_o = 1'b0;
    fsync_o = 1'b0;
    serial_audio_in_o = 1'b0;
    got = 32'h0;
  end

  // Sends one frame of len bits and captures our slot; the clock stands still between calls.
  task automatic send_frame(input int len, input logic [31:0] word);
    for (int k = 0; k < len; k++) begin
      serial_audio_in_o = (k < 32) ? word[31 - k] : ~serial_audio_in_o;
      fsync_o = (k < 2);
      #80 bclk_o = 1'b1;
      if (k < 32) got[31 - k] = serial_audio_out_i;
      #80 bclk_o = 1'b0;
    end
    serial_audio_in_o = ~serial_audio_in_o;
  endtask : send_frame
endmodule : audio_partner

// ---- dv/tb.sv ----
// Self-checking bench for the codec serial port: registers, audio frames, control port.
`timescale 1ns/1ps

module tb;
  import codec_pkg::*;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, di1, pdn_n, lclip, rclip, do1;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, w, rx;
  logic [3:0] wb_sel_i, ver;
  logic [2:0] mode;
  logic [8:1] mp_i, mp_o, mp_oe, mp_w;
  logic bclk_o, bclk_oe, bclk_p, fs_o, fs_oe, fs_p, serial_audio_in, serial_audio_out;
  int errors, checked, seed;

  // Two-way pins resolve to whichever party has its enable up.
  assign mp_w = (mp_oe & mp_o) | (~mp_oe & mp_i);

  codec_serial_port #(.SETTLE_CYC(20), .SCLK_TMO(60)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_select_a_i(mode[0]),
    .mode_select_b_i(mode[1]), .mode_select_c_i(mode[2]), .multi_pin_i(mp_w),
    .multi_pin_o(mp_o), .multi_pin_oe_o(mp_oe),
    .bit_clock_i(bclk_oe ? bclk_o : bclk_p), .bit_clock_o(bclk_o), .bit_clock_oe_o(bclk_oe),
    .frame_sync_i(fs_oe ? fs_o : fs_p), .frame_sync_o(fs_o), .frame_sync_oe_o(fs_oe),
    .serial_audio_in_i(serial_audio_in), .serial_audio_out_o(serial_audio_out), .par_in_bit_1_i(di1),
    .par_out_bit_1_o(do1), .power_down_n_i(pdn_n), .left_clip_flag_i(lclip),
    .right_clip_flag_i(rclip));

  audio_partner i_partner (.bclk_o(bclk_p), .fsync_o(fs_p), .serial_audio_in_o(serial_audio_in), .serial_audio_out_i(serial_audio_out));

  // The system clock runs at 50 MHz.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One classic Wishbone cycle; read data lands in rd at the acknowledging edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) check("ack", 32'h1, 32'h0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Holds reset for ten cycles, then lets calibration finish.
  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask : reset_dut

  // Sends a frame with its edges 7 ns after a system clock edge.
  task automatic frame(input int len, input logic [31:0] x);
    #7;
    i_partner.send_frame(len, x);
    @(posedge clk_i);
  endtask : frame

  // Control port transfer: data moves with the rise, the top status nibble goes to ver.
  task automatic ctrl_xfer(input logic [23:0] cw);
    mp_i[4] <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (8) @(posedge clk_i);
      if (i > 19) ver[i - 20] = mp_o[1];
      mp_i[3] <= 1'b1;
      mp_i[2] <= cw[i];
      repeat (8) @(posedge clk_i);
      mp_i[3] <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    mp_i[4] <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : ctrl_xfer

  // Cuts a hung run short.
  initial begin
    #1_000_000;
    errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    seed = 29029;
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    mode = 3'h0;
    mp_i = 8'h38; // Pin five idles high through its pull-up.
    di1 = 1'b0;
    pdn_n = 1'b1;
    lclip = 1'b0;
    rclip = 1'b0;
    reset_dut();
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl after reset", 32'h0, rd);
    wb(1'b1, 8'h10, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", 32'h0, rd);
    wb(1'b0, REG_STATUS, 32'h0);
    check("mode one valid", 32'h20, rd & 32'h23);
    // Mode one frames with random samples and parallel bits.
    for (int t = 0; t < 3; t++) begin
      w = $random(seed);
      rx = $random(seed);
      {mp_i[4], mp_i[3], mp_i[6], di1} <= w[3:0];
      wb(1'b1, REG_TX, w);
      frame(256, rx);
      frame(256, rx);
      check("tx slot", {w[15:0], 12'h000, w[3:0]}, i_partner.got & 32'hffff000f);
      check("par outputs", 32'(rx[3:0]), 32'({mp_o[1], mp_o[2], mp_o[5], do1}));
      wb(1'b0, REG_RX, 32'h0);
      check("rx word", rx, rd);
    end
    pdn_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    check("powered down", 32'h80, rd & 32'h80);
    pdn_n <= 1'b1;
    mode <= 3'h4;
    mp_i <= 8'h38;
    reset_dut();
    wb(1'b0, REG_STATUS, 32'h0);
    check("mode four", 32'h3, rd & 32'h3);
    w = $random(seed) & 32'h00fffffd;
    ctrl_xfer(w[23:0]);
    check("version", 32'(VERSION_ID), 32'(ver));
    // Four interrupt causes (parallel input one, both clip flags, end of clock error) after a clearing transfer.
    for (int e = 0; e < 4; e++) begin
      ctrl_xfer(w[23:0]);
      check("irq idle", 32'h0, 32'({mp_oe[5], mp_o[5]}));
      case (e)
        0: di1 <= ~di1;
        1: lclip <= 1'b1;
        2: rclip <= 1'b1;
        default: begin
          wb(1'b0, REG_STATUS, 32'h0);
          check("clock error", 32'h18, rd & 32'h18);
          frame(32, 32'h0);
        end
      endcase
      repeat (10) @(posedge clk_i);
      check("irq pin", 32'h2, 32'({mp_oe[5], mp_o[5]}));
      lclip <= 1'b0;
      rclip <= 1'b0;
    end
    ctrl_xfer(w[23:0] | 24'h000002);
    di1 <= ~di1;
    repeat (10) @(posedge clk_i);
    check("masked irq", 32'h0, 32'(mp_oe[5]));
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl word", {8'h00, w[23:0] | 24'h000002}, rd);
    // Mode three master: the device drives both audio clocks at a half period of four system clocks.
    mode <= 3'h2;
    mp_i <= 8'h38;
    reset_dut();
    wb(1'b0, REG_STATUS, 32'h0);
    check("mode three master", 32'h6, rd & 32'h7);
    check("clock drive", 32'h3, 32'({bclk_oe, fs_oe}));
    @(posedge bclk_o);
    repeat (10) @(posedge clk_i);
    check("bit clock high", 32'h1, 32'(bclk_o));
    repeat (20) @(posedge clk_i);
    check("bit clock low", 32'h0, 32'(bclk_o));
    give_verdict();
  end
endmodule : tb
